// file: hw/cof_regs.sv
// comparator offset register bank with command port and offset outputs
`timescale 1ns/1ps
module cof_regs (
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        CMD_VALID,
  input  wire logic [7:0]  CMD_OPCODE,
  input  wire logic [15:0] CMD_WDATA,
  output logic             RSP_VALID,
  output logic [15:0]      RSP_DATA,
  output logic             CMD_UNKNOWN,
  input  wire logic        STOP_EDGE_POLARITY,
  input  wire logic        MEAS_START,
  input  wire logic        EARLY_EDGE_UP,
  input  wire logic        EARLY_EDGE_DN,
  output logic signed [8:0] OFFSET_UP,
  output logic signed [8:0] OFFSET_DN,
  output logic             RETURNED_UP,
  output logic             RETURNED_DN
);
  logic [15:0]      comparator_offset_upstream_q;
  logic [15:0]      comparator_offset_downstream_q;
  logic             rsp_valid_q;
  logic [15:0]      rsp_data_q;
  logic             unknown_q;
  logic             is_rd_up;
  logic             is_rd_dn;
  logic             is_wr_up;
  logic             is_wr_dn;
  logic [15:0]      path_reg    [cof_pkg::NUM_PATHS];
  logic             path_edge   [cof_pkg::NUM_PATHS];
  logic signed [8:0] path_ofs   [cof_pkg::NUM_PATHS];
  logic             path_ret    [cof_pkg::NUM_PATHS];

  // ****************************************
  // command decode
  // ****************************************
  assign is_rd_up = CMD_VALID && (CMD_OPCODE == cof_pkg::OPC_RD_UP);
  assign is_rd_dn = CMD_VALID && (CMD_OPCODE == cof_pkg::OPC_RD_DN);
  assign is_wr_up = CMD_VALID && (CMD_OPCODE == cof_pkg::OPC_WR_UP);
  assign is_wr_dn = CMD_VALID && (CMD_OPCODE == cof_pkg::OPC_WR_DN);

  // ****************************************
  // registers
  // ****************************************
  // all 16 bits are stored as written so a read returns exactly what the host sent
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      comparator_offset_upstream_q <= cof_pkg::UP_DEFAULT;
    end else if (is_wr_up) begin
      comparator_offset_upstream_q <= CMD_WDATA;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      comparator_offset_downstream_q <= cof_pkg::DN_DEFAULT;
    end else if (is_wr_dn) begin
      comparator_offset_downstream_q <= CMD_WDATA;
    end
  end

  // ****************************************
  // read response
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= is_rd_up | is_rd_dn;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rsp_data_q <= 16'h0000;
    end else if (is_rd_dn) begin
      rsp_data_q <= comparator_offset_downstream_q;
    end else if (is_rd_up) begin
      rsp_data_q <= comparator_offset_upstream_q;
    end
  end

  // unknown opcodes are dropped; the pulse lets the host side notice
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      unknown_q <= 1'b0;
    end else begin
      unknown_q <= CMD_VALID & ~(is_rd_up | is_rd_dn | is_wr_up | is_wr_dn);
    end
  end

  assign RSP_VALID   = rsp_valid_q;
  assign RSP_DATA    = rsp_data_q;
  assign CMD_UNKNOWN = unknown_q;

  // ****************************************
  // offset paths
  // ****************************************
  assign path_reg[cof_pkg::PATH_UP]  = comparator_offset_upstream_q;
  assign path_reg[cof_pkg::PATH_DN]  = comparator_offset_downstream_q;
  assign path_edge[cof_pkg::PATH_UP] = EARLY_EDGE_UP;
  assign path_edge[cof_pkg::PATH_DN] = EARLY_EDGE_DN;

  for (genvar p = 0; p < cof_pkg::NUM_PATHS; p++) begin : g_path
    cof_path_sel u_sel (
      .clock              (CLOCK),
      .reset              (RESET),
      .reg_value          (path_reg[p]),
      .stop_edge_polarity (STOP_EDGE_POLARITY),
      .meas_start         (MEAS_START),
      .early_edge         (path_edge[p]),
      .offset_q           (path_ofs[p]),
      .returned_q         (path_ret[p])
    );
  end

  assign OFFSET_UP   = path_ofs[cof_pkg::PATH_UP];
  assign OFFSET_DN   = path_ofs[cof_pkg::PATH_DN];
  assign RETURNED_UP = path_ret[cof_pkg::PATH_UP];
  assign RETURNED_DN = path_ret[cof_pkg::PATH_DN];

  // ****************************************
  // checks
  // ****************************************
  chk_read_dn_data: assert property (@(posedge CLOCK) disable iff (RESET)
    is_rd_dn |=> (RSP_VALID && RSP_DATA == $past(comparator_offset_downstream_q)))
    else $error("downstream read returned wrong data");
  chk_dn_reset_zero: assert property (@(posedge CLOCK)
    $past(RESET) |-> (comparator_offset_downstream_q == 16'h0000 && !RSP_VALID))
    else $error("downstream register not zero after reset");
  chk_dn_write_store: assert property (@(posedge CLOCK) disable iff (RESET)
    is_wr_dn |=> comparator_offset_downstream_q == $past(CMD_WDATA))
    else $error("downstream write not stored");
  chk_dn_return_sign: assert property (@(posedge CLOCK) disable iff (RESET)
    (EARLY_EDGE_DN && comparator_offset_downstream_q[15] && !is_wr_dn) |=> OFFSET_DN < 0)
    else $error("negative return code not negative");
  chk_up_write_store: assert property (@(posedge CLOCK) disable iff (RESET)
    is_wr_up |=> comparator_offset_upstream_q == $past(CMD_WDATA))
    else $error("upstream write not stored");
  chk_rsv_ignored: assert property (@(posedge CLOCK) disable iff (RESET)
    (!EARLY_EDGE_UP && !RETURNED_UP && !MEAS_START && !STOP_EDGE_POLARITY) |=>
      OFFSET_UP[8:7] == 2'h0)
    else $error("reserved bit leaked into upstream threshold");
  chk_no_spurious_rsp: assert property (@(posedge CLOCK) disable iff (RESET)
    !(is_rd_up || is_rd_dn) |=> !RSP_VALID)
    else $error("response without read command");

  // ****************************************
  // port level checks
  // ****************************************
  // all but chk_dn_hold and chk_up_hold watch the top ports, so a wiring slip between the two paths shows up here
  chk_read_up_data: assert property (@(posedge CLOCK) disable iff (RESET)
    is_rd_up |=>
      (RSP_VALID && RSP_DATA == $past(comparator_offset_upstream_q)))
    else $error("upstream read returned wrong data");
  chk_rsp_data_hold: assert property (@(posedge CLOCK) disable iff (RESET)
    !(is_rd_up || is_rd_dn) |=>
      $stable(RSP_DATA))
    else $error("read data changed without a read");
  chk_unknown_no_rsp: assert property (@(posedge CLOCK) disable iff (RESET)
    CMD_UNKNOWN |->
      !RSP_VALID)
    else $error("unknown opcode produced an answer");
  chk_known_no_flag: assert property (@(posedge CLOCK) disable iff (RESET)
    (is_rd_up || is_rd_dn || is_wr_up || is_wr_dn) |=>
      !CMD_UNKNOWN)
    else $error("mapped opcode flagged as unknown");
  chk_dn_hold: assert property (@(posedge CLOCK) disable iff (RESET)
    !is_wr_dn |=>
      $stable(comparator_offset_downstream_q))
    else $error("downstream register changed without a write");
  chk_up_hold: assert property (@(posedge CLOCK) disable iff (RESET)
    !is_wr_up |=>
      $stable(comparator_offset_upstream_q))
    else $error("upstream register changed without a write");
  chk_dn_ret_value: assert property (@(posedge CLOCK) disable iff (RESET)
    EARLY_EDGE_DN |=>
      OFFSET_DN == $signed({$past(comparator_offset_downstream_q[15]),
                            $past(comparator_offset_downstream_q[15:8])}))
    else $error("downstream return offset not sign extended");
  chk_dn_ret_positive: assert property (@(posedge CLOCK) disable iff (RESET)
    (EARLY_EDGE_DN && !comparator_offset_downstream_q[15]) |=>
      OFFSET_DN >= 0)
    else $error("positive return code not positive");
  chk_up_ret_value: assert property (@(posedge CLOCK) disable iff (RESET)
    EARLY_EDGE_UP |=>
      OFFSET_UP == $signed({$past(comparator_offset_upstream_q[15]),
                            $past(comparator_offset_upstream_q[15:8])}))
    else $error("upstream return offset not applied");
  chk_dn_returned_flag: assert property (@(posedge CLOCK) disable iff (RESET)
    EARLY_EDGE_DN |=>
      RETURNED_DN)
    else $error("downstream path not on return offset");
  chk_up_returned_flag: assert property (@(posedge CLOCK) disable iff (RESET)
    EARLY_EDGE_UP |=>
      RETURNED_UP)
    else $error("upstream path not on return offset");
  chk_start_clears: assert property (@(posedge CLOCK) disable iff (RESET)
    (MEAS_START && !EARLY_EDGE_DN) |=>
      !RETURNED_DN)
    else $error("measurement start did not restore threshold");
  chk_dn_thr_rise: assert property (@(posedge CLOCK) disable iff (RESET)
    (!EARLY_EDGE_DN && (!RETURNED_DN || MEAS_START) && !STOP_EDGE_POLARITY) |=>
      OFFSET_DN == $signed({2'h0, $past(comparator_offset_downstream_q[6:0])}))
    else $error("downstream rising threshold wrong");
  chk_dn_thr_fall: assert property (@(posedge CLOCK) disable iff (RESET)
    (!EARLY_EDGE_DN && (!RETURNED_DN || MEAS_START) && STOP_EDGE_POLARITY) |=>
      OFFSET_DN == -$signed({2'h0, $past(comparator_offset_downstream_q[6:0])}))
    else $error("downstream falling threshold wrong");
  chk_up_thr_range: assert property (@(posedge CLOCK) disable iff (RESET)
    (!EARLY_EDGE_UP && (!RETURNED_UP || MEAS_START)) |=>
      (OFFSET_UP <= 127 && OFFSET_UP >= -127))
    else $error("upstream threshold out of range");
  chk_outputs_reset: assert property (@(posedge CLOCK)
    $past(RESET) |->
      (OFFSET_UP == 0 && OFFSET_DN == 0 && !RETURNED_UP && !RETURNED_DN && !CMD_UNKNOWN))
    else $error("path outputs not cleared by reset");
endmodule

// file: pkg/cof_pkg.sv
// constants for the comparator offset register bank
package cof_pkg;
  // ****************************************
  // command opcodes
  // ****************************************
  localparam logic [7:0] OPC_RD_DN = 8'hbe;
  localparam logic [7:0] OPC_RD_UP = 8'h90;
  localparam logic [7:0] OPC_WR_UP = 8'h10;
  localparam logic [7:0] OPC_WR_DN = 8'h11;

  // ****************************************
  // field layout
  // ****************************************
  localparam int RET_MSB = 15;
  localparam int RET_LSB = 8;
  localparam int RSV_BIT = 7;
  localparam int THR_MSB = 6;
  localparam int THR_LSB = 0;
  localparam int REG_W   = 16;
  localparam int OFS_W   = 9;
  localparam int NUM_PATHS = 2;
  localparam int PATH_UP   = 0;
  localparam int PATH_DN   = 1;

  // ****************************************
  // nonvolatile defaults
  // ****************************************
  localparam logic [15:0] DN_DEFAULT = 16'h0000;
  localparam logic [15:0] UP_DEFAULT = 16'h0000;
endpackage

// file: hw/cof_path_sel.sv
// per-path comparator offset selection: threshold before early edge, return after
`timescale 1ns/1ps
module cof_path_sel (
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire logic [cof_pkg::REG_W-1:0] reg_value,
  input  wire logic                      stop_edge_polarity,
  input  wire logic                      meas_start,
  input  wire logic                      early_edge,
  output logic signed [cof_pkg::OFS_W-1:0] offset_q,
  output logic                           returned_q
);
  logic                           returned_d;
  logic [cof_pkg::OFS_W-1:0]      thr_mag;
  logic [cof_pkg::OFS_W-1:0]      thr_ofs;
  logic [cof_pkg::OFS_W-1:0]      ret_ofs;
  logic [cof_pkg::OFS_W-1:0]      offset_d;

  // ****************************************
  // early edge flag
  // ****************************************
  // an early edge in the same cycle as a new measurement start wins
  assign returned_d = early_edge | (returned_q & ~meas_start);

  always_ff @(posedge clock) begin
    if (reset) begin
      returned_q <= 1'b0;
    end else begin
      returned_q <= returned_d;
    end
  end

  // ****************************************
  // offset forming
  // ****************************************
  // bit 7 never enters either field, so a stray host write there is harmless
  assign thr_mag = {2'h0, reg_value[cof_pkg::THR_MSB:cof_pkg::THR_LSB]};
  assign thr_ofs = stop_edge_polarity ? (9'h000 - thr_mag) : thr_mag;
  assign ret_ofs = {reg_value[cof_pkg::RET_MSB], reg_value[cof_pkg::RET_MSB:cof_pkg::RET_LSB]};
  assign offset_d = returned_d ? ret_ofs : thr_ofs;

  always_ff @(posedge clock) begin
    if (reset) begin
      offset_q <= 9'sh000;
    end else begin
      offset_q <= offset_d;
    end
  end

  chk_return_switch: assert property (@(posedge clock) disable iff (reset)
    early_edge |=> offset_q == $signed($past(ret_ofs)))
    else $error("return offset not applied after early edge");
  chk_rising_positive: assert property (@(posedge clock) disable iff (reset)
    (!returned_d && !stop_edge_polarity) |=>
      offset_q == $signed({2'h0, $past(reg_value[6:0])}))
    else $error("rising threshold offset wrong");
  chk_falling_negative: assert property (@(posedge clock) disable iff (reset)
    (!returned_d && stop_edge_polarity) |=>
      offset_q == -$signed({2'h0, $past(reg_value[6:0])}))
    else $error("falling threshold offset wrong");
  chk_return_hold: assert property (@(posedge clock) disable iff (reset)
    (returned_q && !meas_start) |=> returned_q)
    else $error("return state dropped without measurement start");
endmodule

// file: dv/cof_host.sv
// host model that issues commands to the offset register bank
`timescale 1ns/1ps
module cof_host (
  input  wire logic   clock,
  output logic        cmd_valid,
  output logic [7:0]  cmd_opcode,
  output logic [15:0] cmd_wdata
);
  // ****************************************
  // command issue
  // ****************************************
  initial begin
    cmd_valid  = 1'b0;
    cmd_opcode = 8'h00;
    cmd_wdata  = 16'h0000;
  end
  // idle lines carry the inverse of the last opcode and of d before its bit 7 mask, so stale values are never mistaken
  task automatic send(input logic [7:0] op, input logic [15:0] d);
    @(posedge clock);
    cmd_valid  <= 1'b1;
    cmd_opcode <= op;
    cmd_wdata  <= d & 16'hff7f;
    @(posedge clock);
    cmd_valid  <= 1'b0;
    cmd_opcode <= ~op;
    cmd_wdata  <= ~d;
  endtask
endmodule

// file: dv/cof_regs_bench.sv
// self-checking bench for the comparator offset register bank
`timescale 1ns/1ps
module cof_regs_bench;
  logic              clock, reset, cmd_valid, rsp_valid, cmd_unknown;
  logic              pol, meas_start, ee_up, ee_dn, ret_up, ret_dn;
  logic [7:0]        cmd_opcode, c;
  logic [15:0]       cmd_wdata, rsp_data, w, u;
  logic signed [8:0] offset_up, offset_dn, e;
  logic [15:0]       exp_q[$];
  logic [7:0]        codes [5] = '{8'h7f, 8'h01, 8'h00, 8'h80, 8'hff};
  logic [7:0]        bad [3] = '{8'h00, 8'hff, 8'hbf};
  int                error_cnt = 0;
  int                total_checks = 0;
  int                unk_cnt = 0;
  cof_host cof_host_inst (.clock(clock), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_wdata(cmd_wdata));
  cof_regs cof_regs_inst (.CLOCK(clock), .RESET(reset), .CMD_VALID(cmd_valid),
    .CMD_OPCODE(cmd_opcode), .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .CMD_UNKNOWN(cmd_unknown), .STOP_EDGE_POLARITY(pol),
    .MEAS_START(meas_start), .EARLY_EDGE_UP(ee_up), .EARLY_EDGE_DN(ee_dn),
    .OFFSET_UP(offset_up), .OFFSET_DN(offset_dn), .RETURNED_UP(ret_up),
    .RETURNED_DN(ret_dn));
  // ****************************************
  // checking
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_ofs(input logic [8:0] got, input logic [8:0] exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] op, input logic [15:0] x);
    exp_q.push_back(x);
    cof_host_inst.send(op, 16'h0000);
    for (int n = 0; n < 8 && exp_q.size() > 0; n++) @(posedge clock);
    if (exp_q.size() > 0) begin
      error_cnt++;
      $display("Error %0t read answer missing", $time);
      test_done();
    end
  endtask
  // answers are paired with the oldest pending read
  always @(posedge clock) begin
    if (cmd_unknown === 1'b1)
      unk_cnt++;
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() > 0)
        chk(rsp_data, exp_q.pop_front());
      else begin
        error_cnt++;
        $display("Error %0t answer without read", $time);
      end
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    {reset, pol, meas_start, ee_up, ee_dn} = 5'h10;
    void'($urandom(32'h18f1));
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    rd(cof_pkg::OPC_RD_DN, 16'h0000);
    rd(cof_pkg::OPC_RD_UP, cof_pkg::UP_DEFAULT);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom());
      u = 16'($urandom());
      cof_host_inst.send(cof_pkg::OPC_WR_DN, w);
      cof_host_inst.send(cof_pkg::OPC_WR_UP, u);
      rd(cof_pkg::OPC_RD_DN, w & 16'hff7f);
      rd(cof_pkg::OPC_RD_UP, u & 16'hff7f);
      pol <= i[0];
      repeat (3) @(posedge clock);
      @(negedge clock);
      e = {2'h0, w[6:0]};
      chk_ofs(offset_dn, i[0] ? -e : e);
      e = {2'h0, u[6:0]};
      chk_ofs(offset_up, i[0] ? -e : e);
    end
    $display("threshold test done");
    @(posedge clock);
    pol <= 1'b0;
    foreach (codes[k]) begin
      c = codes[k];
      cof_host_inst.send(cof_pkg::OPC_WR_DN, {c, 8'h05});
      cof_host_inst.send(cof_pkg::OPC_WR_UP, {c, 8'h05});
      meas_start <= 1'b1;
      @(posedge clock);
      meas_start <= 1'b0;
      @(negedge clock);
      chk({15'h0000, ret_dn}, 16'h0000);
      chk_ofs(offset_dn, 9'h005);
      @(posedge clock);
      {ee_up, ee_dn} <= 2'h3;
      @(posedge clock);
      {ee_up, ee_dn} <= 2'h0;
      @(negedge clock);
      e = {c[7], c};
      chk_ofs(offset_dn, e);
      chk_ofs(offset_up, e);
      chk({14'h0000, ret_up, ret_dn}, 16'h0003);
    end
    $display("return test done");
    // unmapped opcodes must only raise the unknown pulse, never an answer
    foreach (bad[k]) cof_host_inst.send(bad[k], 16'h1234);
    repeat (3) @(posedge clock);
    chk(unk_cnt[15:0], 16'h0003);
    $display("unknown opcode test done");
    test_done();
  end
endmodule
